// ===== hdl/ustb_regs.sv
// start-of-frame threshold and descriptor table base register bank
// assumes a single-cycle strobe bus master and a same-clock scheduler
//
// Overview of operation
// [RULE1] threshold register keeps an 8-bit read/write value; upper bits read zero
// [RULE2] software sets threshold per packet size: 0x4a, 0x2a, 0x1a
// [RULE3] for 8-byte packets software loads threshold code 0x12
// [RULE4] low page register bits 7..1 give table base address bits 15..9
// [RULE5] low page register bit 0 reads zero and ignores writes
// [RULE6] middle page register byte gives table base address bits 23..16
// [RULE7] high page register byte gives table base address bits 31..24
// [RULE8] table base is 512-byte aligned; address bits 8..0 stay zero
// [RULE9] composed base is the start of the descriptor table in memory
// [RULE10] bits 31..8 of all four registers read zero, ignore writes
// [RULE11] host mode withholds new tokens when frame tail is below threshold
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
`include "ustb_cfg.svh"
module ustb_regs #(
  parameter int FRAME_BYTES = `USTB_FRAME_BYTES,
  parameter int BYTE_CYCLES = `USTB_BYTE_CYCLES
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // register bus
  input  wire ustb_pkg::ustb_addr_t regAddr,
  input  wire ustb_pkg::ustb_word_t regWrData,
  input  wire logic                 regWrite,
  input  wire logic                 regRead,
  output ustb_pkg::ustb_word_t      regRdData,
  // host scheduler
  input  wire logic                 hostMode,
  input  wire logic                 sofPulse,
  input  wire logic                 tokenReq,
  output logic                      tokenGo,
  output ustb_pkg::ustb_cnt_t       frameBytesLeft,
  // descriptor fetch and threshold
  output ustb_pkg::ustb_word_t      descTableBase,
  output ustb_pkg::ustb_byte_t      sofThreshold
);
  import ustb_pkg::*;

  localparam int NREG = 4;

  // offsets and writable masks, indexed by register
  localparam ustb_addr_t REG_OFS [NREG] = '{
    `USTB_OFS_SOF, `USTB_OFS_BASE_LOW, `USTB_OFS_BASE_MID, `USTB_OFS_BASE_HIGH
  };
  localparam ustb_byte_t REG_MASK [NREG] = '{
    `USTB_MASK_SOF, `USTB_MASK_BASE_LOW, `USTB_MASK_BASE_MID, `USTB_MASK_BASE_HIGH
  };

  // address match against one register offset
  function automatic logic regHit(input ustb_addr_t addr, input ustb_addr_t ofs);
    regHit = (addr == ofs);
  endfunction

  ustb_byte_t field_reg [NREG];
  ustb_byte_t readByte;
  ustb_word_t rdData_reg;
  ustb_word_t rdData_next;
  logic [NREG-1:0] hitVec;
  logic       anyHit;
  ustb_byte_t wrByte;

  assign wrByte = regWrData[`USTB_FIELD_W-1:0];

  // per-register decode and storage
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      assign hitVec[gi] = regHit(regAddr, REG_OFS[gi]);

      // [RULE5] masked write keeps unimplemented bits zero
      always_ff @(posedge clk or posedge reset)
      begin
        if (reset)
          field_reg[gi] <= `USTB_RST_FIELD;
        else if (regWrite && hitVec[gi])
          field_reg[gi] <= wrByte & REG_MASK[gi];
      end
    end
  endgenerate

  // read selection, unmapped offsets answer zero
  assign anyHit   = |hitVec;
  assign readByte = hitVec[0] ? field_reg[0] :
                    hitVec[1] ? field_reg[1] :
                    hitVec[2] ? field_reg[2] :
                    hitVec[3] ? field_reg[3] : '0;

  // [RULE10] only the low byte is ever returned
  assign rdData_next = regRead ? {{(`USTB_DATA_W-`USTB_FIELD_W){1'b0}}, readByte} : '0;

  // read data stand for one cycle after the strobe
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdData_reg <= '0;
    else
      rdData_reg <= rdData_next;
  end

  assign regRdData = rdData_reg;

  // [RULE1] threshold value to the scheduler
  assign sofThreshold = field_reg[0];

  // [RULE8] compose the 512-byte aligned table base
  assign descTableBase = {field_reg[3], field_reg[2], field_reg[1][7:1],
                          {`USTB_ALIGN_BITS{1'b0}}};

  // [RULE11] frame tail gate for host tokens
  ustb_frame_gate #(
    .FRAME_BYTES (FRAME_BYTES),
    .BYTE_CYCLES (BYTE_CYCLES)
  ) u_gate (
    .clk       (clk),
    .reset     (reset),
    .hostMode  (hostMode),
    .sofPulse  (sofPulse),
    .tokenReq  (tokenReq),
    .threshold (field_reg[0]),
    .tokenGo   (tokenGo),
    .bytesLeft (frameBytesLeft)
  );

  // checks below watch the register bank and the gate outputs
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // helper: past-valid flag, set from the first cycle after reset
  logic pastValid_reg;
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      pastValid_reg <= 1'b0;
    else
      pastValid_reg <= 1'b1;
  end

  a_rd_upper_zero: assert property ( // [RULE10]
    regRdData[`USTB_DATA_W-1:`USTB_FIELD_W] == '0)
    else $error("read data upper bits not zero");

  a_sof_write_back: assert property ( // [RULE1]
    regWrite && hitVec[0] |=> sofThreshold == $past(wrByte))
    else $error("threshold did not take written value");

  a_sof_read_back: assert property ( // [RULE1]
    regWrite && hitVec[0] ##1 (regRead && hitVec[0] && !regWrite)
    |=> regRdData[7:0] == $past(wrByte, 2))
    else $error("threshold read back differs from write");

  a_low_bit_zero: assert property ( // [RULE5]
    regRead && hitVec[1] |=> regRdData[0] == 1'b0)
    else $error("low page bit 0 read as one");

  a_low_page_map: assert property ( // [RULE4]
    regWrite && hitVec[1] |=> descTableBase[15:9] == $past(wrByte[7:1]))
    else $error("low page field not at base bits 15..9");

  a_mid_page_map: assert property ( // [RULE6]
    regWrite && hitVec[2] |=> descTableBase[23:16] == $past(wrByte))
    else $error("middle page field not at base bits 23..16");

  a_high_page_map: assert property ( // [RULE7]
    regWrite && hitVec[3] |=> descTableBase[31:24] == $past(wrByte))
    else $error("high page field not at base bits 31..24");

  a_base_aligned: assert property ( // [RULE8]
    descTableBase[8:0] == 9'h000)
    else $error("table base not 512-byte aligned");

  a_base_hold: assert property ( // [RULE9]
    !(regWrite && (hitVec[1] || hitVec[2] || hitVec[3])) |=> $stable(descTableBase))
    else $error("table base moved without a page write");

  a_base_read: assert property ( // [RULE9]
    regRead && hitVec[3] |=> regRdData[7:0] == descTableBase[31:24])
    else $error("high page read differs from table base");

  a_rd_one_cycle: assert property ( // [RULE10]
    pastValid_reg && !$past(regRead) |-> regRdData == '0)
    else $error("read data outside the answer cycle");

  a_unmapped_zero: assert property ( // [RULE10]
    regRead && !anyHit |=> regRdData == '0)
    else $error("unmapped read not zero");

  a_token_gate: assert property ( // [RULE11]
    tokenGo |-> hostMode && frameBytesLeft >= ustb_cnt_t'(sofThreshold))
    else $error("token started inside frame tail");

  a_sof_reload: assert property ( // [RULE11]
    sofPulse |=> frameBytesLeft == ustb_cnt_t'(FRAME_BYTES))
    else $error("frame count not reloaded at start of frame");

  // main scenarios
  c_thr_64b: cover property (regWrite && hitVec[0] && wrByte == `USTB_THR_64B);
  c_thr_8b: cover property (regWrite && hitVec[0] && wrByte == `USTB_THR_8B);
  c_token_go: cover property (tokenGo);
  c_token_held: cover property (tokenReq && hostMode && !tokenGo && frameBytesLeft != '0);
endmodule // ustb_regs

// ===== hdl/ustb_cfg.svh
// register offsets, field positions, reset values and timing counts
// assumes a 50 MHz core clock and a full-speed link with 1 ms frames
`ifndef USTB_CFG_SVH
`define USTB_CFG_SVH

// register bus geometry
`define USTB_ADDR_W        8
`define USTB_DATA_W        32
`define USTB_FIELD_W       8

// register byte offsets, one aligned word each
`define USTB_OFS_SOF       8'h00
`define USTB_OFS_BASE_LOW  8'h04
`define USTB_OFS_BASE_MID  8'h08
`define USTB_OFS_BASE_HIGH 8'h0c

// writable bit masks of the implemented low byte
`define USTB_MASK_SOF       8'hff
`define USTB_MASK_BASE_LOW  8'hfe
`define USTB_MASK_BASE_MID  8'hff
`define USTB_MASK_BASE_HIGH 8'hff

// reset values
`define USTB_RST_FIELD     8'h00

// field positions inside the composed table base
`define USTB_BASE_LOW_LSB  9
`define USTB_BASE_MID_LSB  16
`define USTB_BASE_HIGH_LSB 24
`define USTB_ALIGN_BITS    9

// suggested threshold codes per largest packet size
`define USTB_THR_64B       8'h4a
`define USTB_THR_32B       8'h2a
`define USTB_THR_16B       8'h1a
`define USTB_THR_8B        8'h12

// timing: clock and link rates in kHz, frame period in us
`define USTB_CLK_KHZ       50000
`define USTB_BIT_KHZ       12000
`define USTB_FRAME_US      1000
`define USTB_BYTE_CYCLES   ((8 * `USTB_CLK_KHZ) / `USTB_BIT_KHZ)
`define USTB_FRAME_BYTES   ((`USTB_FRAME_US * `USTB_BIT_KHZ) / 8000)
`define USTB_CNT_W         11

`endif

// ===== hdl/ustb_pkg.sv
// types shared by the threshold/table-base register bank
// assumes ustb_cfg.svh is reachable on the include path
package ustb_pkg;
  `include "ustb_cfg.svh"

  // one implemented byte of a register
  typedef logic [`USTB_FIELD_W-1:0] ustb_byte_t;

  // bus address and data words
  typedef logic [`USTB_ADDR_W-1:0] ustb_addr_t;
  typedef logic [`USTB_DATA_W-1:0] ustb_word_t;

  // remaining byte times in a frame
  typedef logic [`USTB_CNT_W-1:0] ustb_cnt_t;

  // token gate states, one-hot
  typedef enum logic [2:0] {
    USTB_WAIT_SOF = 3'b001,
    USTB_OPEN     = 3'b010,
    USTB_SHUT     = 3'b100
  } ustb_gate_t;
endpackage

// ===== hdl/ustb_frame_gate.sv
// host-mode token gate: counts byte times left in the frame
// assumes sofPulse and tokenReq come from logic on the same clock
`timescale 1ns/1ps
`include "ustb_cfg.svh"
module ustb_frame_gate #(
  parameter int FRAME_BYTES = `USTB_FRAME_BYTES,
  parameter int BYTE_CYCLES = `USTB_BYTE_CYCLES
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            reset,
  // scheduler side
  input  wire logic            hostMode,
  input  wire logic            sofPulse,
  input  wire logic            tokenReq,
  input  wire ustb_pkg::ustb_byte_t threshold,
  // results
  output logic                 tokenGo,
  output ustb_pkg::ustb_cnt_t  bytesLeft
);
  import ustb_pkg::*;

  localparam ustb_cnt_t FRAME_LOAD = ustb_cnt_t'(FRAME_BYTES);
  localparam ustb_cnt_t BYTE_LAST  = ustb_cnt_t'(BYTE_CYCLES - 1);

  ustb_gate_t state_reg;
  ustb_gate_t state_next;
  ustb_cnt_t  left_reg;
  ustb_cnt_t  left_next;
  ustb_cnt_t  pre_reg;
  ustb_cnt_t  pre_next;
  logic       byteTick;
  logic       belowThr;

  // byte-time prescaler and frame countdown
  assign byteTick  = (pre_reg == BYTE_LAST);
  assign pre_next  = (sofPulse || byteTick) ? '0 : pre_reg + ustb_cnt_t'(1);
  assign left_next = sofPulse ? FRAME_LOAD :
                     (byteTick && left_reg != '0) ? left_reg - ustb_cnt_t'(1) : left_reg;
  assign belowThr  = (left_reg < ustb_cnt_t'(threshold));

  // gate state: shut once the frame tail is shorter than the threshold
  always_comb
  begin
    case (state_reg)
      USTB_WAIT_SOF: state_next = sofPulse ? USTB_OPEN : USTB_WAIT_SOF;
      USTB_OPEN:     state_next = sofPulse ? USTB_OPEN : (belowThr ? USTB_SHUT : USTB_OPEN);
      USTB_SHUT:     state_next = sofPulse ? USTB_OPEN : USTB_SHUT;
      default:       state_next = USTB_WAIT_SOF;
    endcase
  end

  // registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= USTB_WAIT_SOF;
      left_reg  <= '0;
      pre_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      left_reg  <= left_next;
      pre_reg   <= pre_next;
    end
  end

  // [RULE11] threshold blocks late tokens
  assign tokenGo   = tokenReq && hostMode && (state_reg == USTB_OPEN) && !belowThr;
  assign bytesLeft = left_reg;
endmodule // ustb_frame_gate

// ===== verif/ustb_mem_model.sv
// far-side memory holding the descriptor table
// assumes the fetch address is the composed table base
`timescale 1ns/1ps
module ustb_mem_model (
  // fetch address from the controller
  input  wire logic [31:0] fetchAddr,
  // first word of the table
  output logic      [31:0] entryWord
);
  // aligned start returns data, else a fault word
  assign entryWord = (fetchAddr[8:0] == 9'h000) ? (fetchAddr ^ 32'h5a5a5a5a) : 32'hffffffff;
endmodule // ustb_mem_model

// ===== verif/test_usb_sof_threshold_and_bdt_base.sv
// self-checking bench for the threshold and table-base registers
// assumes ustb_cfg.svh on the include path; frame shortened
`timescale 1ns/1ps
`include "ustb_cfg.svh"
module test_usb_sof_threshold_and_bdt_base;
  import ustb_pkg::*;
  localparam int FB = 40;
  localparam int BC = 2;
  logic        clk, reset, regWrite, regRead, hostMode, sofPulse;
  logic        tokenReq, tokenGo;
  logic        rdPend = 1'b0;
  ustb_addr_t  regAddr;
  ustb_word_t  regWrData, regRdData, descTableBase, entryWord, d;
  ustb_byte_t  sofThreshold;
  ustb_cnt_t   frameBytesLeft;
  ustb_word_t  expQ[$];
  ustb_byte_t  ex[4];
  ustb_byte_t  mk[4] = '{8'hff, 8'hfe, 8'hff, 8'hff};
  ustb_byte_t  codes[4] = '{`USTB_THR_64B, `USTB_THR_32B, `USTB_THR_16B, `USTB_THR_8B};
  int          miscompares, checks, cycles;

  // design and far-side memory
  ustb_regs #(.FRAME_BYTES(FB), .BYTE_CYCLES(BC)) ustb_regs_inst (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .hostMode(hostMode), .sofPulse(sofPulse), .tokenReq(tokenReq),
    .tokenGo(tokenGo), .frameBytesLeft(frameBytesLeft),
    .descTableBase(descTableBase), .sofThreshold(sofThreshold));
  ustb_mem_model ustb_mem_model_inst (.fetchAddr(descTableBase), .entryWord(entryWord));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task check(input ustb_word_t seen, input ustb_word_t exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task wr(input ustb_addr_t a, input ustb_word_t v);
    @(posedge clk);
    regAddr   <= a;
    regWrData <= v;
    regWrite  <= 1'b1;
    @(posedge clk);
    regWrite  <= 1'b0;
  endtask

  // read strobe, expected value noted for the monitor
  task rd(input ustb_addr_t a, input ustb_word_t v);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(v);
    @(posedge clk);
    regRead <= 1'b0;
  endtask

  // read data stands the cycle after the strobe
  always @(posedge clk)
  begin
    if (rdPend)
      check(regRdData, expQ.pop_front());
    rdPend <= regRead;
  end

  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      close_out();
    end
  end

  initial
  begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    hostMode = 1'b0;
    sofPulse = 1'b0;
    tokenReq = 1'b0;
    miscompares = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(63096));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    // cleared registers after reset
    for (int i = 0; i < 4; i++)
      rd(8'(4 * i), 32'h0);
    check(descTableBase, 32'h0);
    $display("test reset values done");
    // random words with upper garbage, each suggested threshold code
    for (int n = 0; n < 4; n++)
    begin
      for (int i = 0; i < 4; i++)
      begin
        d = $urandom();
        if (i == 0)
          d[7:0] = codes[n];
        wr(8'(4 * i), d);
        ex[i] = d[7:0] & mk[i];
      end
      for (int i = 0; i < 4; i++)
        rd(8'(4 * i), {24'h0, ex[i]});
      rd(8'h10, 32'h0);
      #1;
      check(descTableBase, {ex[3], ex[2], ex[1][7:1], 9'h000});
      check({24'h0, sofThreshold}, {24'h0, ex[0]});
      check(entryWord, {ex[3], ex[2], ex[1][7:1], 9'h000} ^ 32'h5a5a5a5a);
    end
    $display("test register map done");
    // token gate with threshold 8'h12 over a shortened frame
    @(posedge clk);
    hostMode <= 1'b1;
    tokenReq <= 1'b1;
    @(negedge clk);
    check({31'h0, tokenGo}, 32'h0);
    @(posedge clk);
    sofPulse <= 1'b1;
    @(posedge clk);
    sofPulse <= 1'b0;
    @(negedge clk);
    check(32'(frameBytesLeft), 32'(FB));
    check({31'h0, tokenGo}, 32'h1);
    for (int k = 0; k < 100 && tokenGo !== 1'b0; k++)
      @(negedge clk);
    check(32'(frameBytesLeft), 32'(`USTB_THR_8B) - 32'h1);
    // device mode never starts tokens
    @(posedge clk);
    hostMode <= 1'b0;
    sofPulse <= 1'b1;
    @(posedge clk);
    sofPulse <= 1'b0;
    @(negedge clk);
    check({31'h0, tokenGo}, 32'h0);
    $display("test token gate done");
    close_out();
  end
endmodule // test_usb_sof_threshold_and_bdt_base
